//--- rtl/rx_fifo_ctl_consts.vh
// Constants for the receive status word and FIFO controller
`ifndef RX_FIFO_CTL_CONSTS_VH
`define RX_FIFO_CTL_CONSTS_VH
// Status word bit positions
`define ST_FILT_FAIL 30
`define ST_LEN_HI 29
`define ST_LEN_LO 16
`define ST_SUMMARY_ERR 15
`define ST_BCAST 13
`define ST_LEN_MISMATCH 12
`define ST_RUNT 11
`define ST_MCAST 10
`define ST_TOO_LONG 7
`define ST_LATE_COLL 6
`define ST_FRAME_TYPE 5
`define ST_WDOG 4
`define ST_MII_ERR 3
`define ST_DRIBBLE 2
`define ST_CRC_ERR 1
// Frame size limits in bytes
`define COLL_WINDOW_BYTES 14'd64
`define MAX_FRAME_BYTES 14'd1518
`define WDOG_BYTES 14'd2048
`define MIN_TYPE_BYTES 14'd14
`define MAX_LEN_FIELD 16'd1500
// Register offsets
`define REG_CTRL 4'h0
`define REG_STATUS 4'h4
`define REG_RX_LEVEL 4'h8
`define REG_TX_LEVEL 4'hc
// Control register fields
`define CTRL_RX_EN 0
`define CTRL_RX_FLUSH 1
`define CTRL_PASS_BAD 16
`define CTRL_RESET 32'h0000_0000
// Status register fields
`define STAT_RX_STOPPED 0
`define STAT_RX_OVERFLOW 1
`endif

//--- rtl/rx_fifo_ctl.v
// Receive status builder, receive FIFO and transmit FIFO write and read sides
//
// The Wishbone register port and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`include "rx_fifo_ctl_consts.vh"
module rx_fifo_ctl #(
    parameter RX_AW = 13,
    parameter TX_AW = 11
) (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    // Wishbone slave
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [3:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // MAC transfer interface, receive
    input wire mac_rx_valid_i,
    input wire [31:0] mac_rx_data_i,
    input wire mac_rx_end_i,
    input wire [13:0] mac_rx_bytes_i,
    input wire mac_rx_filt_fail_i,
    input wire mac_rx_bcast_i,
    input wire mac_rx_mcast_i,
    input wire [15:0] mac_rx_len_type_i,
    input wire mac_rx_late_coll_i,
    input wire mac_rx_er_i,
    input wire mac_rx_dribble_i,
    input wire mac_rx_crc_bad_i,
    output reg mac_rx_active_o,
    // Bulk-in engine read side
    input wire rx_rd_i,
    output reg [31:0] rx_rd_data_o,
    output reg rx_rd_avail_o,
    // Bulk-out engine write side
    input wire tx_wr_valid_i,
    input wire [31:0] tx_wr_data_i,
    input wire tx_wr_commit_i,
    input wire tx_wr_rewind_i,
    output reg tx_wr_ready_o,
    // Transmit read side and receiver stop event
    input wire tx_rd_i,
    output reg [31:0] tx_rd_data_o,
    output reg tx_rd_avail_o,
    output reg receive_stopped_event_o
);

    localparam RX_DEPTH = 1 << RX_AW;
    localparam TX_DEPTH = 1 << TX_AW;

    // ----------------------------------------
    // Storage
    // ----------------------------------------
    reg [31:0] rx_mem [0:RX_DEPTH-1];
    reg [31:0] tx_mem [0:TX_DEPTH-1]; // 2048 words = 8 kB

    reg [31:0] ctrl_reg;
    reg overflow_reg;
    reg [RX_AW:0] rx_wr_ptr_reg;
    reg [RX_AW:0] receive_write_head_pointer_reg;
    reg [RX_AW:0] rx_rd_ptr_reg;
    reg [TX_AW:0] tx_wr_ptr_reg;
    reg [TX_AW:0] transmit_write_head_pointer_reg;
    reg [TX_AW:0] tx_rd_ptr_reg;
    reg in_frame_reg;
    reg drop_reg;
    reg stopped_reg;

    // Ring distance between pointers
    function [RX_AW:0] rx_used;
        input [RX_AW:0] a;
        input [RX_AW:0] b;
        begin
            rx_used = a - b;
        end
    endfunction

    // ----------------------------------------
    // Status word assembly
    // ----------------------------------------
    wire [13:0] len = mac_rx_bytes_i;
    wire runt = len < `COLL_WINDOW_BYTES;
    wire too_long = len > `MAX_FRAME_BYTES;
    wire wdog = len > `WDOG_BYTES;
    wire late = mac_rx_late_coll_i;
    // Receive error forces CRC error even on good CRC
    wire crc_err = mac_rx_crc_bad_i | mac_rx_er_i;
    // Type frame only when long enough to carry the field
    wire ftype = (mac_rx_len_type_i > `MAX_LEN_FIELD) && !(len < `MIN_TYPE_BYTES);
    // Length mismatch only checked for 802.3 length fields
    wire len_mis = (mac_rx_len_type_i <= `MAX_LEN_FIELD) && (mac_rx_len_type_i != {2'b00, len} - 16'd14);
    // Late collision masks dribble
    wire dribble = mac_rx_dribble_i & ~late;
    reg [31:0] status_word;
    always @* begin
        status_word = 32'h0000_0000;
        status_word[`ST_FILT_FAIL] = mac_rx_filt_fail_i;
        status_word[`ST_LEN_HI:`ST_LEN_LO] = len;
        status_word[`ST_BCAST] = mac_rx_bcast_i;
        status_word[`ST_MCAST] = mac_rx_mcast_i;
        status_word[`ST_LEN_MISMATCH] = len_mis;
        status_word[`ST_RUNT] = runt;
        status_word[`ST_TOO_LONG] = too_long;
        status_word[`ST_LATE_COLL] = late;
        status_word[`ST_FRAME_TYPE] = ftype;
        status_word[`ST_WDOG] = wdog;
        status_word[`ST_MII_ERR] = mac_rx_er_i;
        status_word[`ST_DRIBBLE] = dribble;
        // CRC bit also set by a receive error; host ignores it for these cases
        status_word[`ST_CRC_ERR] = crc_err;
        status_word[`ST_SUMMARY_ERR] = runt | too_long | late | crc_err;
    end

    // ----------------------------------------
    // Receive FIFO write side
    // ----------------------------------------
    wire rx_en = ctrl_reg[`CTRL_RX_EN];
    wire flush_req = ctrl_reg[`CTRL_RX_FLUSH];
    wire [RX_AW:0] rx_fill = rx_used(rx_wr_ptr_reg, rx_rd_ptr_reg);
    wire rx_full = rx_fill >= RX_DEPTH - 1;
    wire rx_rd_ok = rx_rd_i && rx_rd_ptr_reg != receive_write_head_pointer_reg;
    wire frame_start = mac_rx_valid_i && !in_frame_reg && rx_en;
    // Runts dropped unless pass-bad is set
    wire keep_frame = !runt || ctrl_reg[`CTRL_PASS_BAD];
    wire wr_data = mac_rx_valid_i && (in_frame_reg || frame_start) && !drop_reg && !mac_rx_end_i;
    // First data word lands just past the reserved head slot
    wire [RX_AW-1:0] rx_wr_addr = frame_start ? receive_write_head_pointer_reg[RX_AW-1:0] + 1'b1
        : rx_wr_ptr_reg[RX_AW-1:0];

    // Head slot is skipped at frame start and filled at end
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_wr_ptr_reg <= {(RX_AW+1){1'b0}};
            receive_write_head_pointer_reg <= {(RX_AW+1){1'b0}};
            rx_rd_ptr_reg <= {(RX_AW+1){1'b0}};
            in_frame_reg <= 1'b0;
            drop_reg <= 1'b0;
            overflow_reg <= 1'b0;
        end else if (ce_i) begin
            if (flush_req && !in_frame_reg) begin
                rx_wr_ptr_reg <= {(RX_AW+1){1'b0}};
                receive_write_head_pointer_reg <= {(RX_AW+1){1'b0}};
                rx_rd_ptr_reg <= {(RX_AW+1){1'b0}};
            end else begin
                if (rx_rd_ok)
                    rx_rd_ptr_reg <= rx_rd_ptr_reg + 1'b1;
                if (frame_start) begin
                    in_frame_reg <= 1'b1;
                    drop_reg <= rx_full;
                    rx_wr_ptr_reg <= receive_write_head_pointer_reg + 1'b1;
                end
                if (wr_data) begin
                    if (rx_full) begin
                        // Overflow marks the frame dropped; rest ignored, pointer rewound at the end beat
                        drop_reg <= 1'b1;
                        overflow_reg <= 1'b1;
                    end else begin
                        rx_mem[rx_wr_addr] <= mac_rx_data_i;
                        rx_wr_ptr_reg <= (frame_start ? receive_write_head_pointer_reg + 1'b1 : rx_wr_ptr_reg)
                            + 1'b1;
                    end
                end
                if (mac_rx_valid_i && mac_rx_end_i && in_frame_reg) begin
                    in_frame_reg <= 1'b0;
                    drop_reg <= 1'b0;
                    if (!drop_reg && keep_frame) begin
                        // Publishing the head makes the frame visible
                        rx_mem[receive_write_head_pointer_reg[RX_AW-1:0]] <= status_word;
                        receive_write_head_pointer_reg <= rx_wr_ptr_reg;
                    end else begin
                        rx_wr_ptr_reg <= receive_write_head_pointer_reg;
                    end
                end
            end
        end
    end

    // ----------------------------------------
    // Receiver stop handshake
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            stopped_reg <= 1'b1;
            receive_stopped_event_o <= 1'b0;
            mac_rx_active_o <= 1'b0;
        end else if (ce_i) begin
            receive_stopped_event_o <= 1'b0;
            mac_rx_active_o <= rx_en | in_frame_reg;
            // Halt only between frames so none is cut
            if (!rx_en && !in_frame_reg && !stopped_reg) begin
                stopped_reg <= 1'b1;
                receive_stopped_event_o <= 1'b1;
            end else if (rx_en) begin
                stopped_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // Receive read port
    // ----------------------------------------
    always @(posedge clk_i) begin
        if (rst_i) begin
            rx_rd_data_o <= 32'h0000_0000;
            rx_rd_avail_o <= 1'b0;
        end else if (ce_i) begin
            rx_rd_data_o <= rx_mem[rx_rd_ptr_reg[RX_AW-1:0]];
            if (rx_rd_ok)
                rx_rd_data_o <= rx_mem[rx_rd_ptr_reg[RX_AW-1:0]];
            rx_rd_avail_o <= (rx_rd_ptr_reg + (rx_rd_ok ? 1'b1 : 1'b0)) != receive_write_head_pointer_reg;
        end
    end

    // ----------------------------------------
    // Transmit FIFO (bulk-out packets)
    // ----------------------------------------
    wire [TX_AW:0] tx_fill = tx_wr_ptr_reg - tx_rd_ptr_reg;
    wire tx_full = tx_fill >= TX_DEPTH;
    wire tx_wr = tx_wr_valid_i && tx_wr_ready_o && !tx_full;
    wire tx_rd_ok = tx_rd_i && tx_rd_ptr_reg != transmit_write_head_pointer_reg;
    always @(posedge clk_i) begin
        if (rst_i) begin
            tx_wr_ptr_reg <= {(TX_AW+1){1'b0}};
            transmit_write_head_pointer_reg <= {(TX_AW+1){1'b0}};
            tx_rd_ptr_reg <= {(TX_AW+1){1'b0}};
            tx_wr_ready_o <= 1'b0;
            tx_rd_data_o <= 32'h0000_0000;
            tx_rd_avail_o <= 1'b0;
        end else if (ce_i) begin
            if (tx_wr_rewind_i) begin
                // Errored packet discarded for host retry
                tx_wr_ptr_reg <= transmit_write_head_pointer_reg;
            end else begin
                if (tx_wr) begin
                    tx_mem[tx_wr_ptr_reg[TX_AW-1:0]] <= tx_wr_data_i;
                    tx_wr_ptr_reg <= tx_wr_ptr_reg + 1'b1;
                end
                if (tx_wr_commit_i)
                    transmit_write_head_pointer_reg <= tx_wr_ptr_reg + (tx_wr ? 1'b1 : 1'b0);
            end
            // Registered ready leaves one spare slot of margin
            tx_wr_ready_o <= tx_fill < TX_DEPTH - 1;
            if (tx_rd_ok)
                tx_rd_ptr_reg <= tx_rd_ptr_reg + 1'b1;
            tx_rd_data_o <= tx_mem[tx_rd_ptr_reg[TX_AW-1:0]];
            tx_rd_avail_o <= (tx_rd_ptr_reg + (tx_rd_ok ? 1'b1 : 1'b0)) != transmit_write_head_pointer_reg;
        end
    end

    // ----------------------------------------
    // Wishbone register slave
    // ----------------------------------------
    wire wb_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    always @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= `CTRL_RESET;
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else if (ce_i) begin
            wb_ack_o <= wb_req;
            // Flush self-clears once pointers are reset
            if (flush_req && !in_frame_reg)
                ctrl_reg[`CTRL_RX_FLUSH] <= 1'b0;
            if (wb_req && wb_we_i && wb_adr_i == `REG_CTRL) begin
                if (wb_sel_i[0])
                    ctrl_reg[7:0] <= wb_dat_i[7:0];
                if (wb_sel_i[2])
                    ctrl_reg[23:16] <= wb_dat_i[23:16];
            end
            case (wb_adr_i)
                `REG_CTRL: wb_dat_o <= ctrl_reg;
                `REG_STATUS: wb_dat_o <= {30'h0, overflow_reg, stopped_reg};
                `REG_RX_LEVEL: wb_dat_o <= {{(31-RX_AW){1'b0}}, rx_fill};
                `REG_TX_LEVEL: wb_dat_o <= {{(31-TX_AW){1'b0}}, tx_fill};
                default: wb_dat_o <= 32'h0000_0000;
            endcase
        end
    end

endmodule // rx_fifo_ctl

//--- verification/rx_fifo_ctl_assertions.sv
// Port checker for the receive status and FIFO controller
`timescale 1ns/1ps
module rx_fifo_ctl_assertions (
    input wire clk_i,
    input wire rst_i,
    input wire ce_i,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire mac_rx_valid_i,
    input wire mac_rx_end_i,
    input wire mac_rx_active_o,
    input wire rx_rd_avail_o,
    input wire tx_wr_commit_i,
    input wire tx_wr_rewind_i,
    input wire tx_rd_avail_o,
    input wire receive_stopped_event_o
);
    default clocking @(posedge clk_i);
    endclocking
    default disable iff (rst_i);
    // End beat as a plain net, so past values can be taken
    wire end_w = mac_rx_valid_i && mac_rx_end_i;
    // Fresh bus request and received end beat
    sequence wb_req_s;
        wb_cyc_i && wb_stb_i && !wb_ack_o && ce_i;
    endsequence
    sequence end_beat_s;
        mac_rx_valid_i && mac_rx_end_i;
    endsequence
    bus_answer_a: assert property (wb_req_s |=> wb_ack_o)
        else $error("bus request not answered");
    ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    ack_cause_a: assert property (wb_ack_o |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    rx_visible_a: assert property ($rose(rx_rd_avail_o) |-> $past(end_w) || $past(end_w, 2))
        else $error("frame visible before its end beat");
    tx_visible_a: assert property ($rose(tx_rd_avail_o) |-> $past(tx_wr_commit_i) || $past(tx_wr_commit_i, 2))
        else $error("packet visible without commit");
    tx_hidden_a: assert property (tx_wr_rewind_i && !tx_rd_avail_o && !tx_wr_commit_i && !$past(tx_wr_commit_i)
        |=> !tx_rd_avail_o [*2]) else $error("rewound packet became visible");
    stop_pulse_a: assert property (receive_stopped_event_o |=> !receive_stopped_event_o)
        else $error("stop event longer than a cycle");
    stop_halted_a: assert property (receive_stopped_event_o |-> !mac_rx_active_o)
        else $error("stop event while receiver active");
    frame_active_a: assert property (end_beat_s |-> mac_rx_active_o)
        else $error("end beat while receiver idle");
endmodule // rx_fifo_ctl_assertions

bind rx_fifo_ctl rx_fifo_ctl_assertions i_rx_fifo_ctl_assertions (
    .clk_i, .rst_i, .ce_i, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .mac_rx_valid_i, .mac_rx_end_i, .mac_rx_active_o,
    .rx_rd_avail_o, .tx_wr_commit_i, .tx_wr_rewind_i, .tx_rd_avail_o, .receive_stopped_event_o
);

//--- verification/mac_partner.sv
// Model of the MAC transfer side that feeds received frames
`timescale 1ns/1ps
module mac_partner (
    input wire clk_i,
    output reg valid_o,
    output reg end_o,
    output reg [31:0] data_o,
    output reg [36:0] info_o
);
    // Idle bus at time zero
    initial begin
        valid_o = 1'b0;
        end_o = 1'b0;
        data_o = 32'h0;
        info_o = 37'h0;
    end
    // Data beats, then the end beat; idle data is inverted so stale words never match
    task send(input [36:0] info, input int n, input bit slow);
        for (int k = 0; k <= n; k++) begin
            @(posedge clk_i);
            valid_o <= 1'b1;
            end_o <= (k == n);
            data_o <= 32'hda7a_0000 + k;
            info_o <= info;
            if (slow && k < n) begin
                @(posedge clk_i);
                valid_o <= 1'b0;
                data_o <= ~data_o;
            end
        end
        @(posedge clk_i);
        valid_o <= 1'b0;
        end_o <= 1'b0;
        data_o <= ~data_o;
    endtask
endmodule // mac_partner

//--- verification/rx_status_and_fifo_control_bench.sv
// Self-checking bench for the receive status and FIFO controller
`timescale 1ns/1ps
module rx_status_and_fifo_control_bench;
    reg clk_i = 1'b0;
    reg rst_i = 1'b1;
    reg cyc = 1'b0, stb = 1'b0, we = 1'b0, rx_rd = 1'b0, tx_rd = 1'b0;
    reg tx_valid = 1'b0, tx_commit = 1'b0, tx_rewind = 1'b0;
    reg [3:0] adr = 4'h0, sel = 4'h0;
    reg [31:0] dat = 32'h0, tx_data = 32'h0, q;
    wire [31:0] rdat, rx_data, tx_rdata, mdata;
    wire ack, active, rx_avail, tx_ready, tx_avail, stop_ev, mvalid, mend;
    wire [36:0] minfo;
    int bad_count = 0;
    int n_tests = 0;
    // Bytes, length/type, filter fail, bcast, mcast, late, rx error, dribble, crc
    reg [36:0] frames [0:4] = '{{14'd100, 16'h0800, 7'h20}, {14'd1600, 16'd46, 7'h1a},
        {14'd2100, 16'h0800, 7'h45}, {14'd10, 16'h0800, 7'h02}, {14'd64, 16'd50, 7'h02}};

    always #2.5 clk_i = ~clk_i;

    mac_partner i_mac_partner (.clk_i(clk_i), .valid_o(mvalid), .end_o(mend), .data_o(mdata), .info_o(minfo));
    rx_fifo_ctl i_rx_fifo_ctl (
        .clk_i(clk_i), .rst_i(rst_i), .ce_i(1'b1), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .mac_rx_valid_i(mvalid), .mac_rx_data_i(mdata), .mac_rx_end_i(mend), .mac_rx_bytes_i(minfo[36:23]),
        .mac_rx_filt_fail_i(minfo[6]), .mac_rx_bcast_i(minfo[5]), .mac_rx_mcast_i(minfo[4]),
        .mac_rx_len_type_i(minfo[22:7]), .mac_rx_late_coll_i(minfo[3]), .mac_rx_er_i(minfo[2]),
        .mac_rx_dribble_i(minfo[1]), .mac_rx_crc_bad_i(minfo[0]), .mac_rx_active_o(active),
        .rx_rd_i(rx_rd), .rx_rd_data_o(rx_data), .rx_rd_avail_o(rx_avail), .tx_wr_valid_i(tx_valid),
        .tx_wr_data_i(tx_data), .tx_wr_commit_i(tx_commit), .tx_wr_rewind_i(tx_rewind), .tx_wr_ready_o(tx_ready),
        .tx_rd_i(tx_rd), .tx_rd_data_o(tx_rdata), .tx_rd_avail_o(tx_avail), .receive_stopped_event_o(stop_ev)
    );

    task check(input string name, input [31:0] exp, input [31:0] got);
        n_tests++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", name, exp, got);
        end
    endtask
    // Classic Wishbone cycle; held until ack is sampled
    task wb(input bit w, input [3:0] a, input [31:0] d, output [31:0] r);
        @(posedge clk_i);
        {cyc, stb, we, adr, sel, dat} <= {2'b11, w, a, 4'hf, d};
        do @(posedge clk_i); while (ack !== 1'b1);
        r = rdat;
        {cyc, stb} <= 2'b00;
    endtask
    // Expected status word from the frame's attributes
    function [31:0] exp_stat(input [36:0] f);
        reg [13:0] b;
        reg [15:0] lt;
        reg [31:0] s;
        b = f[36:23];
        lt = f[22:7];
        s = 32'h0;
        s[30] = f[6];
        s[29:16] = b;
        s[13] = f[5];
        s[10] = f[4];
        s[12] = lt <= 16'd1500 && lt != {2'b00, b} - 16'd14;
        s[11] = b < 14'd64;
        s[7] = b > 14'd1518;
        s[6] = f[3];
        s[5] = lt > 16'd1500 && b >= 14'd14;
        s[4] = b > 14'd2048;
        s[3] = f[2];
        s[2] = f[1] && !f[3];
        s[1] = f[0] || f[2];
        s[15] = s[11] | s[7] | s[6] | s[1];
        return s;
    endfunction
    task pop(input bit tx);
        @(posedge clk_i);
        {tx_rd, rx_rd} <= {tx, !tx};
        @(posedge clk_i);
        {tx_rd, rx_rd} <= 2'b00;
        // Read data is registered from the moved pointer one edge later
        repeat (2) @(posedge clk_i);
    endtask
    // Status first, then both data words, then empty
    task rx_pop(input [31:0] st);
        repeat (3) @(posedge clk_i);
        check("rx status", st, rx_data);
        for (int k = 0; k < 3; k++) begin
            if (k > 0) check("rx data", 32'hda7a_0000 + k - 1, rx_data);
            pop(0);
        end
        check("rx drained", 32'h0, rx_avail);
    endtask
    task tx_push(input int n, input [31:0] base);
        @(posedge clk_i);
        tx_valid <= 1'b1;
        for (int k = 0; k < n; k++) begin
            tx_data <= base + k;
            do @(posedge clk_i); while (tx_ready !== 1'b1);
        end
        tx_valid <= 1'b0;
        tx_data <= ~tx_data;
    endtask
    task tx_mark(input bit rew);
        @(posedge clk_i);
        {tx_rewind, tx_commit} <= {rew, !rew};
        @(posedge clk_i);
        {tx_rewind, tx_commit} <= 2'b00;
    endtask
    task t_regs;
        wb(0, 4'h4, 0, q);
        check("stopped after reset", 32'h1, q);
        wb(1, 4'h2, 32'hffff_ffff, q);
        wb(0, 4'h2, 0, q);
        check("unmapped", 32'h0, q);
        wb(1, 4'h0, 32'h0001_0001, q);
        wb(0, 4'h0, 0, q);
        check("ctrl", 32'h0001_0001, q);
    endtask
    // Every frame kind, runt forwarded while pass-bad is set
    task t_frames;
        for (int i = 0; i < 5; i++) begin
            i_mac_partner.send(frames[i], 2, i[0]);
            rx_pop(exp_stat(frames[i]));
        end
    endtask
    task t_runt_drop;
        wb(1, 4'h0, 32'h1, q);
        i_mac_partner.send({14'd30, 16'd16, 7'h00}, 2, 0);
        repeat (4) @(posedge clk_i);
        check("runt dropped", 32'h0, rx_avail);
    endtask
    // Stop with a frame pending, flush, restart
    task t_stop_flush;
        i_mac_partner.send(frames[0], 2, 0);
        fork
            wb(1, 4'h0, 32'h0, q);
            while (stop_ev !== 1'b1) @(posedge clk_i);
        join
        wb(0, 4'h4, 0, q);
        check("stopped", 32'h1, q);
        wb(1, 4'h0, 32'h2, q);
        repeat (4) @(posedge clk_i);
        wb(0, 4'h0, 0, q);
        check("flush self clear", 32'h0, q);
        check("rx flushed", 32'h0, rx_avail);
        wb(0, 4'h8, 0, q);
        check("rx fill", 32'h0, q);
        wb(1, 4'h0, 32'h1, q);
        i_mac_partner.send(frames[4], 2, 1);
        rx_pop(exp_stat(frames[4]));
    endtask
    task t_tx;
        tx_push(3, 32'h0bad_0000);
        tx_mark(1);
        repeat (3) @(posedge clk_i);
        check("rewound", 32'h0, tx_avail);
        tx_push(2, 32'h7e57_0000);
        tx_mark(0);
        repeat (3) @(posedge clk_i);
        wb(0, 4'hc, 0, q);
        check("tx fill", 32'h2, q);
        for (int k = 0; k < 2; k++) begin
            check("tx data", 32'h7e57_0000 + k, tx_rdata);
            pop(1);
        end
        check("tx drained", 32'h0, tx_avail);
    endtask
    task tally_and_finish;
        if (bad_count == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    // Main sequence
    initial begin
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_regs;
        t_frames;
        t_runt_drop;
        t_stop_flush;
        t_tx;
        tally_and_finish;
    end
    // Watchdog, far beyond the few hundred cycles the tests need
    initial begin
        repeat (20000) @(posedge clk_i);
        bad_count++;
        tally_and_finish;
    end
endmodule // rx_status_and_fifo_control_bench
